/* hdl/pcs_pkg.sv */
// shared constants and types for the packet command sequencer
package pcs_pkg;
   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [5:0] OFF_DATA = 6'h00;
   localparam logic [5:0] OFF_CMD = 6'h04;
   localparam logic [5:0] OFF_TF = 6'h08;
   localparam logic [5:0] OFF_CTL = 6'h0C;
   localparam logic [5:0] OFF_STAT = 6'h10;
   localparam logic [5:0] OFF_BCNT = 6'h14;
   localparam logic [5:0] OFF_DCTL = 6'h18;
   localparam logic [5:0] OFF_DADDR = 6'h1C;
   localparam logic [5:0] OFF_DCNT = 6'h20;
   localparam logic [5:0] OFF_ISTAT = 6'h24;
   localparam logic [5:0] OFF_IMASK = 6'h28;
   // ----------------------------------------
   // field positions and reset values
   // ----------------------------------------
   localparam int BUSY_FLAG_POS = 7;
   localparam int DREQ_FLAG_POS = 3;
   localparam int IRQ_PIO = 0;
   localparam int IRQ_REG = 1;
   localparam int IRQ_DMA = 2;
   localparam logic [7:0] STAT_RST = 8'h00;
   // ----------------------------------------
   // frame type codes seen on the receive side
   // ----------------------------------------
   localparam logic [7:0] FIS_REG_D2H = 8'h34;
   localparam logic [7:0] FIS_PIO_SETUP = 8'h5F;
   localparam logic [7:0] FIS_DMA_ACT = 8'h39;
   // ----------------------------------------
   // outbound fifo geometry and counts
   // ----------------------------------------
   localparam int FIFO_AW = 4;
   localparam logic [4:0] FIFO_DEPTH = 5'h10;
   localparam logic [15:0] WORD_ONE = 16'h1;
   localparam logic [31:0] ADDR_STEP = 32'h2;
   // sequencer states, one-hot
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_SEND = 4'b0010,
      ST_WAIT = 4'b0100,
      ST_PIO = 4'b1000
   } pcs_state_t;
endpackage

/* hdl/pcs_stream_if.sv */
// word stream carrier between sequencer blocks
`timescale 1ns/1ps
interface pcs_stream_if;
   logic [15:0] data;
   logic valid;
   logic ready;
   logic last;
   modport src (output data, output valid, output last, input ready);
   modport snk (input data, input valid, input last, output ready);
endinterface

/* hdl/pcs_txfifo.sv */
// outbound speed matching fifo for shadow data writes
`timescale 1ns/1ps
module pcs_txfifo
   import pcs_pkg::*;
(
   // clock and reset
   input logic clk,
   input logic srst,
   // push and pop streams
   pcs_stream_if.snk push,
   pcs_stream_if.src pop
);
   typedef struct packed {
      logic [FIFO_AW-1:0] wp;
      logic [FIFO_AW-1:0] rp;
      logic [4:0] cnt;
   } pcs_fifo_st_t;
   pcs_fifo_st_t s_r;
   pcs_fifo_st_t s_nxt;
   logic [16:0] mem [0:(1<<FIFO_AW)-1];
   logic wr;
   logic rd;
   // honest full and empty drive both handshakes
   assign push.ready = (s_r.cnt != FIFO_DEPTH);
   assign pop.valid = (s_r.cnt != 5'h0);
   assign pop.data = mem[s_r.rp][15:0];
   assign pop.last = mem[s_r.rp][16];
   assign wr = push.valid && push.ready;
   assign rd = pop.valid && pop.ready;
   // pointer and level update
   always_comb begin
      s_nxt = s_r;
      if (wr) begin
         s_nxt.wp = s_r.wp + 1'b1;
      end
      if (rd) begin
         s_nxt.rp = s_r.rp + 1'b1;
      end
      s_nxt.cnt = s_r.cnt + {4'h0, wr} - {4'h0, rd};
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   // storage has no reset, only the pointers matter
   always_ff @(posedge clk) begin
      if (wr) begin
         mem[s_r.wp] <= {push.last, push.data};
      end
   end
   AST_FIFO_PUSH: assert property (@(posedge clk) disable iff (srst)
      (wr && !rd) |=> (s_r.cnt == $past(s_r.cnt) + 5'h1))
      else $error("fifo push did not raise the level");
endmodule

/* hdl/pcs_dma.sv */
// host side dma engine, memory writes in and memory reads out
`timescale 1ns/1ps
module pcs_dma
   import pcs_pkg::*;
(
   // clock and reset
   input logic clk,
   input logic srst,
   // programming
   input logic run,
   input logic dir_out,
   input logic load,
   input logic active,
   input logic [31:0] addr_init,
   input logic [15:0] count_init,
   // data streams
   pcs_stream_if.snk rx,
   pcs_stream_if.src tx,
   // host memory
   output logic mem_wr_valid,
   output logic [31:0] mem_wr_addr,
   output logic [15:0] mem_wr_data,
   input logic mem_wr_ready,
   output logic mem_rd_req,
   output logic [31:0] mem_rd_addr,
   input logic mem_rd_valid,
   input logic [15:0] mem_rd_data,
   output logic done
);
   typedef struct packed {
      logic [31:0] addr;
      logic [15:0] rem;
      logic wv;
      logic [31:0] wa;
      logic [15:0] wd;
      logic rxr;
      logic rq;
      logic [31:0] ra;
      logic pend;
      logic tv;
      logic [15:0] td;
      logic tl;
      logic done;
   } pcs_dma_st_t;
   pcs_dma_st_t s_r;
   pcs_dma_st_t s_nxt;
   // one word in flight each way keeps the engine small, at best half rate in and a third out
   always_comb begin
      s_nxt = s_r;
      s_nxt.rq = 1'b0;
      s_nxt.done = 1'b0;
      if (s_r.wv && mem_wr_ready) begin
         s_nxt.wv = 1'b0;
      end
      if (s_r.tv && tx.ready) begin
         s_nxt.tv = 1'b0;
      end
      if (load) begin
         s_nxt.addr = addr_init;
         s_nxt.rem = count_init;
      end else begin
         if (rx.valid && s_r.rxr) begin
            s_nxt.wv = 1'b1;
            s_nxt.wa = s_r.addr;
            s_nxt.wd = rx.data;
            s_nxt.addr = s_r.addr + ADDR_STEP;
            s_nxt.rem = s_r.rem - WORD_ONE;
            s_nxt.done = (s_r.rem == WORD_ONE);
         end
         // armed for output stays paused until the drive activates it
         if (run && dir_out && active && s_r.rem != 16'h0 && !s_r.pend && !s_r.tv) begin
            s_nxt.rq = 1'b1;
            s_nxt.ra = s_r.addr;
            s_nxt.pend = 1'b1;
            s_nxt.addr = s_r.addr + ADDR_STEP;
         end
         if (s_r.pend && mem_rd_valid) begin
            s_nxt.pend = 1'b0;
            s_nxt.tv = 1'b1;
            s_nxt.td = mem_rd_data;
            s_nxt.rem = s_r.rem - WORD_ONE;
            s_nxt.tl = (s_r.rem == WORD_ONE);
            s_nxt.done = (s_r.rem == WORD_ONE);
         end
      end
      s_nxt.rxr = run && !dir_out && !load && !s_nxt.wv && s_nxt.rem != 16'h0;
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   // outputs straight from the state
   assign rx.ready = s_r.rxr;
   assign tx.valid = s_r.tv;
   assign tx.data = s_r.td;
   assign tx.last = s_r.tl;
   assign mem_wr_valid = s_r.wv;
   assign mem_wr_addr = s_r.wa;
   assign mem_wr_data = s_r.wd;
   assign mem_rd_req = s_r.rq;
   assign mem_rd_addr = s_r.ra;
   assign done = s_r.done;
   AST_DMA_PAUSED: assert property (@(posedge clk) disable iff (srst)
      (run && dir_out && !active) |=> !mem_rd_req)
      else $error("dma read before activation");
   AST_DMA_COUNT: assert property (@(posedge clk) disable iff (srst)
      (tx.valid && tx.last) |-> (s_r.rem == 16'h0))
      else $error("dma output count does not match programmed count");
endmodule

/* hdl/pcs_seq.sv */
// packet command sequencer top: shadow registers, fis handling, tx path
//
// Our own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
module pcs_seq
   import pcs_pkg::*;
(
   // clock and reset
   input logic CORE_CLK,
   input logic SRST,
   // register bus
   input logic [5:0] AVS_ADDRESS,
   input logic AVS_READ,
   input logic AVS_WRITE,
   input logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // received frames from the link
   input logic RX_FIS_VALID,
   input logic [7:0] RX_FIS_TYPE,
   input logic [7:0] RX_FIS_STATUS,
   input logic [7:0] RX_FIS_ESTATUS,
   input logic [15:0] RX_FIS_COUNT,
   input logic RX_FIS_IRQ,
   input logic RX_FIS_DIR,
   input logic [31:0] RX_FIS_TASKFILE,
   // received data payload
   input logic RX_DATA_VALID,
   input logic [15:0] RX_DATA,
   output logic RX_DATA_READY,
   // register frame to the link
   output logic TX_REG_REQ,
   input logic TX_REG_ACK,
   output logic [7:0] TX_REG_CMD,
   output logic [31:0] TX_REG_TASKFILE,
   output logic [7:0] TX_REG_CTRL,
   // data frame to the link
   output logic TX_DATA_VALID,
   output logic [15:0] TX_DATA,
   output logic TX_DATA_LAST,
   input logic TX_DATA_READY,
   // host memory
   output logic MEM_WR_VALID,
   output logic [31:0] MEM_WR_ADDR,
   output logic [15:0] MEM_WR_DATA,
   input logic MEM_WR_READY,
   output logic MEM_RD_REQ,
   output logic [31:0] MEM_RD_ADDR,
   input logic MEM_RD_VALID,
   input logic [15:0] MEM_RD_DATA,
   // interrupt
   output logic IRQ
);
   // ----------------------------------------
   // state record
   // ----------------------------------------
   typedef struct packed {
      pcs_state_t st;
      logic [7:0] stat;
      logic [7:0] cmd;
      logic [31:0] tf;
      logic [7:0] ctl;
      logic [7:0] estat;
      logic [15:0] wcnt;
      logic [15:0] bcnt;
      logic run;
      logic dir;
      logic act;
      logic load;
      logic [31:0] daddr;
      logic [15:0] dcnt;
      logic [2:0] ist;
      logic [2:0] imask;
      logic irq;
      logic wt;
      logic [31:0] rdata;
      logic treq;
      logic tv;
      logic [15:0] td;
      logic tl;
   } pcs_top_st_t;
   pcs_top_st_t s_r;
   pcs_top_st_t s_nxt;
   logic req;
   logic dwr;
   logic ack;
   logic take;
   logic clr;
   logic [2:0] ev;
   logic [31:0] rd;
   logic dma_done;
   pcs_stream_if fin ();
   pcs_stream_if fout ();
   pcs_stream_if drx ();
   pcs_stream_if dtx ();
   // ----------------------------------------
   // bus handshake
   // ----------------------------------------
   // a data write stalls on a full fifo, so software is throttled
   assign req = (AVS_READ || AVS_WRITE) && s_r.wt;
   assign dwr = AVS_WRITE && (AVS_ADDRESS == OFF_DATA) && (s_r.st == ST_PIO);
   assign ack = req && !(dwr && !fin.ready);
   // fifo push straight from the accepted write
   assign fin.valid = ack && dwr;
   assign fin.data = AVS_WRITEDATA[15:0];
   assign fin.last = (s_r.wcnt == WORD_ONE);
   // incoming payload only reaches a programmed dma
   assign drx.valid = RX_DATA_VALID;
   assign drx.data = RX_DATA;
   assign drx.last = 1'b0;
   // tx stage pulls from fifo first, dma otherwise
   assign take = !s_r.tv || TX_DATA_READY;
   assign fout.ready = take;
   assign dtx.ready = take && !fout.valid;
   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.wt = 1'b1;
      s_nxt.load = 1'b0;
      ev = 3'h0;
      rd = 32'h0;
      clr = 1'b0;
      // software accesses, answered one cycle after being seen
      if (ack) begin
         s_nxt.wt = 1'b0;
         if (AVS_WRITE) begin
            case (AVS_ADDRESS)
               OFF_DATA: begin
                  if (s_r.st == ST_PIO) begin
                     s_nxt.wcnt = s_r.wcnt - WORD_ONE;
                     if (s_r.wcnt == WORD_ONE) begin
                        s_nxt.stat = s_r.estat;
                        s_nxt.st = ST_WAIT;
                     end
                  end
               end
               OFF_CMD: begin
                  s_nxt.cmd = AVS_WRITEDATA[7:0];
                  s_nxt.stat[BUSY_FLAG_POS] = 1'b1;
                  s_nxt.treq = 1'b1;
                  s_nxt.st = ST_SEND;
               end
               OFF_TF: begin
                  s_nxt.tf = AVS_WRITEDATA;
               end
               OFF_CTL: begin
                  s_nxt.ctl = AVS_WRITEDATA[7:0];
               end
               OFF_DCTL: begin
                  s_nxt.run = AVS_WRITEDATA[0];
                  s_nxt.dir = AVS_WRITEDATA[1];
                  s_nxt.load = AVS_WRITEDATA[0] && !s_r.run;
                  if (!AVS_WRITEDATA[0]) begin
                     s_nxt.act = 1'b0;
                  end
               end
               OFF_DADDR: begin
                  s_nxt.daddr = AVS_WRITEDATA;
               end
               OFF_DCNT: begin
                  s_nxt.dcnt = AVS_WRITEDATA[15:0];
               end
               OFF_IMASK: begin
                  s_nxt.imask = AVS_WRITEDATA[2:0];
               end
               default: begin
               end
            endcase
         end else begin
            case (AVS_ADDRESS)
               OFF_CMD: rd = {24'h0, s_r.cmd};
               OFF_TF: rd = s_r.tf;
               OFF_CTL: rd = {24'h0, s_r.ctl};
               OFF_STAT: rd = {24'h0, s_r.stat};
               OFF_BCNT: rd = {16'h0, s_r.bcnt};
               OFF_DCTL: rd = {29'h0, s_r.act, s_r.dir, s_r.run};
               OFF_DADDR: rd = s_r.daddr;
               OFF_DCNT: rd = {16'h0, s_r.dcnt};
               OFF_ISTAT: begin
                  rd = {29'h0, s_r.ist};
                  clr = 1'b1;
               end
               OFF_IMASK: rd = {29'h0, s_r.imask};
               default: rd = 32'h0;
            endcase
         end
         s_nxt.rdata = rd;
      end
      // register frame leaves once the link takes it
      if (s_r.treq && TX_REG_ACK) begin
         s_nxt.treq = 1'b0;
         s_nxt.st = ST_WAIT;
      end
      // frames from the drive
      if (RX_FIS_VALID) begin
         case (RX_FIS_TYPE)
            FIS_PIO_SETUP: begin
               // only host-to-drive transfers are sequenced here
               if (RX_FIS_DIR) begin
                  s_nxt.stat = RX_FIS_STATUS;
                  s_nxt.estat = RX_FIS_ESTATUS;
                  s_nxt.wcnt = RX_FIS_COUNT;
                  s_nxt.bcnt = {RX_FIS_COUNT[14:0], 1'b0};
                  s_nxt.st = ST_PIO;
                  ev[IRQ_PIO] = RX_FIS_IRQ;
               end
            end
            FIS_REG_D2H: begin
               s_nxt.stat = RX_FIS_STATUS;
               s_nxt.tf = RX_FIS_TASKFILE;
               if (!RX_FIS_STATUS[BUSY_FLAG_POS]) begin
                  s_nxt.st = ST_IDLE;
               end
               ev[IRQ_REG] = RX_FIS_IRQ;
            end
            FIS_DMA_ACT: begin
               if (s_r.run && s_r.dir) begin
                  s_nxt.act = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
      // dma finished its programmed count
      if (dma_done) begin
         s_nxt.run = 1'b0;
         s_nxt.act = 1'b0;
         ev[IRQ_DMA] = 1'b1;
      end
      // read clears, but a new event in the same cycle survives
      s_nxt.ist = (clr ? 3'h0 : s_r.ist) | ev;
      s_nxt.irq = |(s_nxt.ist & s_nxt.imask);
      // outbound data stage, frame close rides on the last word
      if (take) begin
         s_nxt.tv = fout.valid || dtx.valid;
         s_nxt.td = fout.valid ? fout.data : dtx.data;
         s_nxt.tl = fout.valid ? fout.last : dtx.last;
      end
   end
   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         s_r <= '0;
         s_r.st <= ST_IDLE;
         s_r.stat <= STAT_RST;
         s_r.wt <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end
   // ----------------------------------------
   // sub blocks
   // ----------------------------------------
   pcs_txfifo u_fifo (
      .clk (CORE_CLK),
      .srst (SRST),
      .push (fin),
      .pop (fout)
   );
   pcs_dma u_dma (
      .clk (CORE_CLK),
      .srst (SRST),
      .run (s_r.run),
      .dir_out (s_r.dir),
      .load (s_r.load),
      .active (s_r.act),
      .addr_init (s_r.daddr),
      .count_init (s_r.dcnt),
      .rx (drx),
      .tx (dtx),
      .mem_wr_valid (MEM_WR_VALID),
      .mem_wr_addr (MEM_WR_ADDR),
      .mem_wr_data (MEM_WR_DATA),
      .mem_wr_ready (MEM_WR_READY),
      .mem_rd_req (MEM_RD_REQ),
      .mem_rd_addr (MEM_RD_ADDR),
      .mem_rd_valid (MEM_RD_VALID),
      .mem_rd_data (MEM_RD_DATA),
      .done (dma_done)
   );
   // ----------------------------------------
   // outputs, all from state flops
   // ----------------------------------------
   assign AVS_WAITREQUEST = s_r.wt;
   assign AVS_READDATA = s_r.rdata;
   assign RX_DATA_READY = drx.ready;
   assign TX_REG_REQ = s_r.treq;
   assign TX_REG_CMD = s_r.cmd;
   assign TX_REG_TASKFILE = s_r.tf;
   assign TX_REG_CTRL = s_r.ctl;
   assign TX_DATA_VALID = s_r.tv;
   assign TX_DATA = s_r.td;
   assign TX_DATA_LAST = s_r.tl;
   assign IRQ = s_r.irq;
   // ----------------------------------------
   // checks
   // ----------------------------------------
   AST_CMD_BUSY: assert property (@(posedge CORE_CLK) disable iff (SRST)
      (ack && AVS_WRITE && AVS_ADDRESS == OFF_CMD) |=> (s_r.stat[BUSY_FLAG_POS] && s_r.treq))
      else $error("command write did not set busy and request");
   AST_PIO_LOAD: assert property (@(posedge CORE_CLK) disable iff (SRST)
      (RX_FIS_VALID && RX_FIS_TYPE == FIS_PIO_SETUP && RX_FIS_DIR)
      |=> (s_r.stat == $past(RX_FIS_STATUS) && s_r.st == ST_PIO))
      else $error("pio setup did not load beginning status");
   AST_FINAL: assert property (@(posedge CORE_CLK) disable iff (SRST)
      (fin.valid && fin.ready && fin.last) |=> (s_r.stat == $past(s_r.estat) && s_r.st == ST_WAIT))
      else $error("final status not loaded after last word");
   AST_WORDCNT: assert property (@(posedge CORE_CLK) disable iff (SRST)
      (fin.valid && fin.ready && !fin.last) |=> (s_r.wcnt == $past(s_r.wcnt) - 16'h1))
      else $error("word counter did not count down");
   AST_REG_LOAD: assert property (@(posedge CORE_CLK) disable iff (SRST)
      (RX_FIS_VALID && RX_FIS_TYPE == FIS_REG_D2H) |=> (s_r.tf == $past(RX_FIS_TASKFILE)))
      else $error("register frame not copied to shadow");
   AST_REG_IRQ: assert property (@(posedge CORE_CLK) disable iff (SRST)
      $rose(s_r.ist[IRQ_REG]) |-> $past(RX_FIS_VALID && RX_FIS_TYPE == FIS_REG_D2H && RX_FIS_IRQ))
      else $error("register interrupt without flag");
   AST_DMA_ROUTE: assert property (@(posedge CORE_CLK) disable iff (SRST)
      (RX_DATA_VALID && RX_DATA_READY) |-> (s_r.run && !s_r.dir))
      else $error("incoming data taken without programmed dma");
endmodule

/* dv/pcs_drive_model.sv */
// link partner model standing in for the attached packet drive
`timescale 1ns/1ps
module pcs_drive_model
   import pcs_pkg::*;
(
   // clock
   input wire logic clk,
   // register frame and data frame from the host
   input wire logic rq,
   input wire logic [7:0] cmd,
   output logic ack,
   input wire logic tv,
   input wire logic [15:0] td,
   input wire logic tl,
   output logic tr,
   // frame headers and payload towards the host
   output logic fv,
   output logic [7:0] ft,
   output logic [7:0] fs,
   output logic [7:0] fe,
   output logic [15:0] fc,
   output logic fi,
   output logic fd,
   output logic [31:0] ftf,
   output logic rv,
   output logic [15:0] rd,
   input wire logic rr
);
   logic [7:0] got_cmd;
   int n_reg;
   logic [16:0] txq[$];
   // ----------------------------
   // drive side behaviour
   // ----------------------------
   initial begin
      // ack and ready are owned by the clocked block below alone
      {fv, ft, fs, fe, fc, fi, fd, ftf, rv, rd} = '0;
      n_reg = 0;
   end
   // random stalls so the outbound fifo really has to hold words
   always @(posedge clk) begin
      tr <= ($urandom_range(3, 0) != 0);
      ack <= rq && !ack && ($urandom_range(1, 0) == 1);
      if (ack && rq) begin
         got_cmd <= cmd;
         n_reg <= n_reg + 1;
      end
      if (tv && tr) begin
         txq.push_back({tl, td});
      end
   end
   // one header pulse; fields only count while valid is high
   task automatic fis(input logic [7:0] t, input logic [7:0] s, input logic [7:0] e, input logic [15:0] c,
      input logic i, input logic d, input logic [31:0] f);
      @(posedge clk);
      fv <= 1'b1;
      ft <= t;
      fs <= s;
      fe <= e;
      fc <= c;
      fi <= i;
      fd <= d;
      ftf <= f;
      @(posedge clk);
      fv <= 1'b0;
   endtask
   // read data as one frame, each word held until the host takes it
   task automatic send(input logic [15:0] b, input int n);
      for (int k = 0; k < n; k++) begin
         int w;
         w = 0;
         @(posedge clk);
         rv <= 1'b1;
         rd <= b + 16'(k);
         do begin
            @(posedge clk);
            w++;
         end while (rr !== 1'b1 && w < 500);
         rv <= 1'b0;
         rd <= ~rd;
      end
   endtask
endmodule

/* dv/testbench.sv */
// self-checking bench for the packet command sequencer
`timescale 1ns/1ps
module testbench
   import pcs_pkg::*;
;
   logic CORE_CLK = 1'b0, SRST = 1'b1, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
   logic [5:0] AVS_ADDRESS = 6'h00;
   logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, MEM_WR_ADDR, MEM_RD_ADDR, RX_FIS_TASKFILE, TX_REG_TASKFILE;
   logic AVS_WAITREQUEST, RX_FIS_VALID, RX_FIS_IRQ, RX_FIS_DIR, RX_DATA_VALID, RX_DATA_READY, IRQ;
   logic [7:0] RX_FIS_TYPE, RX_FIS_STATUS, RX_FIS_ESTATUS, TX_REG_CMD, TX_REG_CTRL;
   logic [15:0] RX_FIS_COUNT, RX_DATA, TX_DATA, MEM_WR_DATA, dword;
   logic TX_REG_REQ, TX_REG_ACK, TX_DATA_VALID, TX_DATA_LAST, TX_DATA_READY, MEM_WR_VALID, MEM_RD_REQ;
   logic MEM_WR_READY = 1'b0, MEM_RD_VALID = 1'b0;
   logic [15:0] MEM_RD_DATA = 16'h0000;
   logic [31:0] q, dbase;
   int n_errors = 0, n_checks = 0, wr_idx = 0, rd_reqs = 0, m;
   pcs_seq pcs_seq_inst (.*);
   pcs_drive_model pcs_drive_model_inst (.clk(CORE_CLK), .rq(TX_REG_REQ), .cmd(TX_REG_CMD), .ack(TX_REG_ACK),
      .tv(TX_DATA_VALID), .td(TX_DATA), .tl(TX_DATA_LAST), .tr(TX_DATA_READY), .fv(RX_FIS_VALID),
      .ft(RX_FIS_TYPE), .fs(RX_FIS_STATUS), .fe(RX_FIS_ESTATUS), .fc(RX_FIS_COUNT), .fi(RX_FIS_IRQ),
      .fd(RX_FIS_DIR), .ftf(RX_FIS_TASKFILE), .rv(RX_DATA_VALID), .rd(RX_DATA), .rr(RX_DATA_READY));
   // ----------------------------
   // clock, memory and helpers
   // ----------------------------
   always #2 CORE_CLK = ~CORE_CLK;
   function automatic logic [15:0] memf(input logic [31:0] a);
      return a[16:1] ^ 16'h5A5A;
   endfunction
   // host memory: random write stalls, reads answered one cycle later
   always @(posedge CORE_CLK) begin
      MEM_WR_READY <= ($urandom_range(1, 0) == 1);
      MEM_RD_VALID <= MEM_RD_REQ;
      MEM_RD_DATA <= MEM_RD_REQ ? memf(MEM_RD_ADDR) : ~MEM_RD_DATA;
      if (MEM_RD_REQ === 1'b1) begin
         rd_reqs <= rd_reqs + 1;
      end
      if (MEM_WR_VALID === 1'b1 && MEM_WR_READY === 1'b1) begin
         chk(MEM_WR_ADDR, dbase + ADDR_STEP * 32'(wr_idx));
         chk(MEM_WR_DATA, 16'(dword + wr_idx));
         wr_idx <= wr_idx + 1;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic tmo();
      n_errors++;
      $display("ERROR %0t: wait ran out", $time);
      end_sim();
   endtask
   // one avalon transfer, held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge CORE_CLK);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      AVS_WRITE <= wr;
      AVS_READ <= !wr;
      do begin
         @(posedge CORE_CLK);
         n++;
      end while (AVS_WAITREQUEST !== 1'b0 && n < 500);
      q = AVS_READDATA;
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
      if (n >= 500) tmo();
   endtask
   task automatic rdc(input logic [5:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   // shadow blocks first, command register last
   task automatic command();
      logic [7:0] c;
      logic [31:0] t;
      int r, w;
      c = 8'($urandom);
      t = $urandom;
      r = pcs_drive_model_inst.n_reg;
      w = 0;
      bus(1'b1, OFF_TF, t);
      bus(1'b1, OFF_CTL, 32'h08);
      bus(1'b1, OFF_CMD, {24'h0, c});
      bus(1'b0, OFF_STAT, 32'h0);
      chk(q[BUSY_FLAG_POS], 1'b1);
      while (pcs_drive_model_inst.n_reg == r && w++ < 2000) @(posedge CORE_CLK);
      if (w > 2000) tmo();
      chk(pcs_drive_model_inst.got_cmd, c);
      chk(TX_REG_TASKFILE, t);
      chk(TX_REG_CTRL, 32'h08);
   endtask
   // setup frame, software writes the counted words, frame must close
   task automatic pio(input logic f);
      int n, w;
      logic [15:0] d[$];
      n = $urandom_range(6, 1);
      w = 0;
      pcs_drive_model_inst.txq.delete();
      pcs_drive_model_inst.fis(FIS_PIO_SETUP, 8'h08, 8'h80, 16'(n), f, 1'b1, 32'h0);
      repeat (3) @(posedge CORE_CLK);
      chk(IRQ, f);
      rdc(OFF_STAT, 32'h08);
      rdc(OFF_BCNT, 32'(2 * n));
      rdc(OFF_ISTAT, {31'h0, f});
      for (int k = 0; k < n; k++) begin
         d.push_back(16'($urandom));
         bus(1'b1, OFF_DATA, {16'h0, d[k]});
      end
      rdc(OFF_STAT, 32'h80);
      bus(1'b1, OFF_DATA, 32'h0000BEEF);
      while (pcs_drive_model_inst.txq.size() < n && w++ < 2000) @(posedge CORE_CLK);
      if (w > 2000) tmo();
      repeat (20) @(posedge CORE_CLK);
      chk(pcs_drive_model_inst.txq.size(), n);
      for (int k = 0; k < n; k++) chk(pcs_drive_model_inst.txq[k], {k == n - 1, d[k]});
   endtask
   // completing register frame; mask only gates the output pin
   task automatic complete(input logic f, input logic mk);
      logic [31:0] t;
      t = $urandom;
      pcs_drive_model_inst.fis(FIS_REG_D2H, 8'h50, 8'h00, 16'h0, f, 1'b0, t);
      repeat (3) @(posedge CORE_CLK);
      chk(IRQ, f & mk);
      rdc(OFF_STAT, 32'h50);
      rdc(OFF_TF, t);
      rdc(OFF_ISTAT, {30'h0, f, 1'b0});
   endtask
   // ----------------------------
   // main sequence
   // ----------------------------
   initial begin
      int w, r;
      void'($urandom(6025));
      repeat (5) @(posedge CORE_CLK);
      SRST <= 1'b0;
      rdc(OFF_STAT, {24'h0, STAT_RST});
      rdc(6'h3C, 32'h0);
      bus(1'b1, OFF_IMASK, 32'h7);
      $display("test reset done");
      command();
      pio(1'b0);
      pio(1'b1);
      complete(1'b0, 1'b1);
      bus(1'b1, OFF_IMASK, 32'h0);
      complete(1'b1, 1'b0);
      bus(1'b1, OFF_IMASK, 32'h7);
      complete(1'b1, 1'b1);
      // read-direction setup and an unarmed activate must both be ignored
      pcs_drive_model_inst.fis(FIS_PIO_SETUP, 8'h08, 8'h80, 16'h4, 1'b1, 1'b0, 32'h0);
      pcs_drive_model_inst.fis(FIS_DMA_ACT, 8'h0, 8'h0, 16'h0, 1'b0, 1'b0, 32'h0);
      repeat (3) @(posedge CORE_CLK);
      chk(IRQ, 1'b0);
      rdc(OFF_STAT, 32'h50);
      rdc(OFF_DCTL, 32'h0);
      $display("test pio out done");
      for (int p = 0; p < 2; p++) begin
         dbase = $urandom & 32'h00FFFFFE;
         dword = 16'($urandom);
         m = $urandom_range(8, 1);
         wr_idx = 0;
         r = rd_reqs;
         w = 0;
         bus(1'b1, OFF_DADDR, dbase);
         bus(1'b1, OFF_DCNT, 32'(m));
         bus(1'b1, OFF_DCTL, {30'h0, p[0], 1'b1});
         command();
         pio(1'b0);
         if (p == 0) begin
            pcs_drive_model_inst.send(dword, m);
            while (wr_idx < m && w++ < 2000) @(posedge CORE_CLK);
            chk(wr_idx, m);
         end else begin
            repeat (30) @(posedge CORE_CLK);
            chk(rd_reqs - r, 0);
            rdc(OFF_DCTL, 32'h3);
            pcs_drive_model_inst.txq.delete();
            pcs_drive_model_inst.fis(FIS_DMA_ACT, 8'h0, 8'h0, 16'h0, 1'b0, 1'b0, 32'h0);
            while (pcs_drive_model_inst.txq.size() < m && w++ < 2000) @(posedge CORE_CLK);
            repeat (20) @(posedge CORE_CLK);
            chk(pcs_drive_model_inst.txq.size(), m);
            for (int k = 0; k < m; k++) chk(pcs_drive_model_inst.txq[k], {k == m - 1, memf(dbase + 32'(2 * k))});
         end
         if (w > 2000) tmo();
         rdc(OFF_ISTAT, 32'h4);
         complete(1'b1, 1'b1);
         $display("test dma pass %0d done", p);
      end
      end_sim();
   end
endmodule
